// ===== rtl/ccs_defines.vh
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_A_CTRL 8'h00
`define CCS_A_TOPO 8'h04
`define CCS_A_PRE 8'h08
`define CCS_A_FULL 8'h0C
`define CCS_A_DIS 8'h10
`define CCS_A_BANK0 8'h14
`define CCS_A_BANK1 8'h18
`define CCS_A_IVL 8'h1C
`define CCS_A_STAT 8'h20
`define CCS_A_RES 8'h24
`define CCS_C_RUN 0
`define CCS_C_START 1
`define CCS_C_BANK 2
`define CCS_T_DIFF 0
`define CCS_T_FLOAT 1
`define CCS_T_REFINT 2
`define CCS_T_CINT 3
`define CCS_T_CEXT 4
`define CCS_T_CR 5
`define CCS_T_DCB 6
`define CCS_T_FORCE 7
`define CCS_T_PEN 15:8
`define CCS_T_CYSEL 17:16
`define CCS_T_FAKE 21:18
`define CCS_TOPO_RST 22'h000108
`define CCS_TIME 9:0
`define CCS_DIS_RST 10'h001
`define CCS_B_AVG 12:0
`define CCS_B_TRIG 17:16
`define CCS_IVL0 15:0
`define CCS_IVL1 31:16
`define CCS_CY_OHF4 2'h2
`define CCS_CY_OHF 2'h3
`define CCS_TRIG_A 2'h0
`define CCS_TRIG_B 2'h1
`define CCS_TRIG_TMR 2'h2
`define CCS_TRIG_PIN 2'h3
`define CCS_K_LO 3'h0
`define CCS_K_UP 3'h1
`define CCS_K_BOTH 3'h2
`define CCS_K_RLO 3'h3
`define CCS_K_RUP 3'h4
`define CCS_K_DC 3'h5
`define CCS_SLOT_REF 4'h0
`define CCS_SLOT_INT 4'h9
`define CCS_SLOT_END 4'hA
`define CCS_PORT_REF_EXT 4'h0
`define CCS_PORT_REF_INT 4'h8
`define CCS_NPORT 4'h8
`define CCS_NPAIR 4'h4
`define CCS_FULL_EXTRA 11'h002
`define CCS_DIS_EXTRA 11'h001
`endif

// ===== rtl/ccs_sequencer.v
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_sequencer #(
  parameter MEAS_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire low_freq_oscillator,
  input wire high_freq_oscillator,
  input wire discharge_comparator,
  input wire trigger_pin,
  input wire start_request,
  output reg lower_port_switch,
  output reg upper_port_switch,
  output reg [3:0] lower_port_index,
  output reg [3:0] upper_port_index,
  output reg dummy_charge_enable,
  output reg dc_dummy_active,
  output wire precharge_active,
  output wire fullcharge_active,
  output wire discharge_active,
  output reg result_strobe,
  output reg [MEAS_W-1:0] result_time,
  output reg result_fake,
  output reg end_of_conversion,
  output reg conversion_busy
);
  localparam S_IDLE = 6'h01;
  localparam S_SEEK = 6'h02;
  localparam S_PRE = 6'h04;
  localparam S_FULL = 6'h08;
  localparam S_DIS = 6'h10;
  localparam S_DONE = 6'h20;

  // oscillators and pins are asynchronous; the first stage feeds only the second
  wire [3:0] async_in;
  wire [3:0] sync_lvl;
  wire [3:0] sync_rise;
  assign async_in = {trigger_pin, discharge_comparator, high_freq_oscillator,
                     low_freq_oscillator};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg meta;
      reg stab;
      reg prev;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta <= 1'b0;
          stab <= 1'b0;
          prev <= 1'b0;
        end else if (ce) begin
          meta <= async_in[gi];
          stab <= meta;
          prev <= stab;
        end
      end
      assign sync_lvl[gi] = stab;
      assign sync_rise[gi] = stab & ~prev;
    end
  endgenerate
  wire olf_rise = sync_rise[0];
  wire ohf_rise = sync_rise[1];
  wire comp_trip = sync_lvl[2];
  wire pin_rise = sync_rise[3];

  reg [5:0] st;
  reg run;
  reg bank_sel;
  reg [21:0] topo;
  reg [9:0] pre_t;
  reg [9:0] full_t;
  reg [9:0] dis_t;
  reg [17:0] bank0;
  reg [17:0] bank1;
  reg [31:0] ivl;
  reg [21:0] s_topo;
  reg [9:0] s_pre;
  reg [9:0] s_full;
  reg [9:0] s_dis;
  reg [3:0] slot;
  reg [2:0] kind;
  reg [3:0] fake_left;
  reg [12:0] seq_left;
  reg [10:0] pcnt;
  reg [MEAS_W-1:0] mcnt;
  reg tripped;
  reg armed;
  reg [1:0] div4;
  reg [16:0] tcnt;
  reg thit;
  reg cmd_pend;
  reg pin_pend;
  reg [15:0] conv_cnt;
  reg [3:0] res_port;

  assign precharge_active = st[2];
  assign fullcharge_active = st[3];
  assign discharge_active = st[4];

  // apb decode; the slave answers in the first access cycle
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire [MEAS_W+15:0] res_wide = {16'h0000, result_time};
  reg [31:0] rd;
  reg hit;
  always @* begin
    hit = 1'b1;
    rd = 32'h00000000;
    case (paddr)
      `CCS_A_CTRL: rd = {29'h0, bank_sel, 1'b0, run};
      `CCS_A_TOPO: rd = {10'h000, topo};
      `CCS_A_PRE: rd = {22'h000000, pre_t};
      `CCS_A_FULL: rd = {22'h000000, full_t};
      `CCS_A_DIS: rd = {22'h000000, dis_t};
      `CCS_A_BANK0: rd = {14'h0000, bank0};
      `CCS_A_BANK1: rd = {14'h0000, bank1};
      `CCS_A_IVL: rd = ivl;
      `CCS_A_STAT: rd = {conv_cnt, 5'h00, kind, slot, 2'h0, fake_left != 4'h0,
                         conversion_busy};
      `CCS_A_RES: rd = {12'h000, res_port, res_wide[15:0]};
      default: hit = 1'b0;
    endcase
  end

  // live bank drives trigger decode; averaging is latched at start
  wire [17:0] bk = bank_sel ? bank1 : bank0;
  wire [15:0] ivl_now = bank_sel ? ivl[`CCS_IVL1] : ivl[`CCS_IVL0];
  wire [1:0] trig = bk[`CCS_B_TRIG];
  wire ivl_zero = (ivl_now == 16'h0000);
  wire m_stretch = (trig == `CCS_TRIG_A) & ~ivl_zero;
  wire m_cont = (trig == `CCS_TRIG_B) & ~ivl_zero;
  wire m_single = (trig == `CCS_TRIG_B) & ivl_zero;
  wire m_timer = (trig == `CCS_TRIG_TMR);
  wire m_pin = (trig == `CCS_TRIG_PIN);

  // conversion timer counts twice the low-frequency period per unit
  wire [16:0] tgoal = {ivl_now, 1'b0};
  wire [16:0] tcnt_inc = tcnt + 17'h00001;
  wire treach = olf_rise & (tgoal != 17'h00000) & (tcnt_inc >= tgoal);

  wire go = run & st[0] & (m_cont
            | ((m_stretch | m_timer) & thit)
            | (m_single & cmd_pend) | (m_pin & pin_pend));
  wire cmd_evt = start_request | (wr & (paddr == `CCS_A_CTRL) & pwdata[`CCS_C_START]);
  wire [12:0] avg = bk[`CCS_B_AVG];

  // ohf is sampled by pclk, so it must stay well below half the pclk rate
  wire [1:0] cysel = s_topo[`CCS_T_CYSEL];
  wire tick = (cysel == `CCS_CY_OHF) ? ohf_rise :
              (cysel == `CCS_CY_OHF4) ? (ohf_rise & (div4 == 2'h3)) : olf_rise;

  // step qualification for the current slot and kind
  wire floating = s_topo[`CCS_T_FLOAT];
  wire sgl_gnd = ~s_topo[`CCS_T_DIFF] & ~floating;
  wire [7:0] pen = s_topo[`CCS_T_PEN];
  reg [3:0] cand;
  reg [3:0] lo_idx;
  reg slot_ok;
  reg kind_ok;
  reg sw_lo;
  reg sw_up;
  always @* begin
    cand = s_topo[`CCS_T_REFINT] ? (slot - 4'h1) : slot;
    if (slot == `CCS_SLOT_REF)
      slot_ok = 1'b1;
    else if (slot == `CCS_SLOT_INT)
      slot_ok = s_topo[`CCS_T_CINT];
    else if (slot >= `CCS_SLOT_END)
      slot_ok = 1'b0;
    else if (floating)
      slot_ok = (cand < `CCS_NPAIR) & pen[{cand[1:0], 1'b0}];
    else
      slot_ok = (cand < `CCS_NPORT) & pen[cand[2:0]];
    if (slot == `CCS_SLOT_REF)
      lo_idx = s_topo[`CCS_T_REFINT] ? `CCS_PORT_REF_INT : `CCS_PORT_REF_EXT;
    else if (floating)
      lo_idx = {cand[2:0], 1'b0};
    else
      lo_idx = cand;
    kind_ok = 1'b0;
    sw_lo = 1'b0;
    sw_up = 1'b0;
    if (slot == `CCS_SLOT_INT) begin
      kind_ok = (kind == `CCS_K_LO);
    end else begin
      case (kind)
        `CCS_K_LO: begin
          kind_ok = 1'b1;
          sw_lo = 1'b1;
        end
        `CCS_K_UP: begin
          kind_ok = floating;
          sw_up = 1'b1;
        end
        `CCS_K_BOTH: begin
          kind_ok = floating & s_topo[`CCS_T_CEXT];
          sw_lo = 1'b1;
          sw_up = 1'b1;
        end
        `CCS_K_RLO: begin
          kind_ok = s_topo[`CCS_T_CR];
          sw_lo = 1'b1;
        end
        `CCS_K_RUP: begin
          kind_ok = floating & s_topo[`CCS_T_CR];
          sw_up = 1'b1;
        end
        `CCS_K_DC: begin
          kind_ok = s_topo[`CCS_T_DCB] & ~sgl_gnd;
          sw_lo = 1'b1;
        end
        default: kind_ok = 1'b0;
      endcase
    end
  end
  wire last_kind = (kind == `CCS_K_DC) | (slot == `CCS_SLOT_INT);

  // phase lengths in cycle base periods, unsigned
  wire [10:0] dur = st[2] ? {1'b0, s_pre} :
                    st[3] ? ({1'b0, s_full} + `CCS_FULL_EXTRA) :
                    ({1'b0, s_dis} + `CCS_DIS_EXTRA);
  wire [10:0] pcnt_inc = pcnt + 11'h001;
  wire phase_end = tick & (pcnt_inc >= dur);
  wire [MEAS_W-1:0] mcnt_inc = mcnt + {{(MEAS_W-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      run <= 1'b0;
      bank_sel <= 1'b0;
      topo <= `CCS_TOPO_RST;
      pre_t <= 10'h000;
      full_t <= 10'h000;
      dis_t <= `CCS_DIS_RST;
      bank0 <= 18'h00000;
      bank1 <= 18'h00000;
      ivl <= 32'h00000000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup)
        prdata <= rd;
      if (wr) begin
        case (paddr)
          `CCS_A_CTRL: begin
            run <= pwdata[`CCS_C_RUN];
            bank_sel <= pwdata[`CCS_C_BANK];
          end
          `CCS_A_TOPO: topo <= pwdata[21:0];
          `CCS_A_PRE: pre_t <= pwdata[`CCS_TIME];
          `CCS_A_FULL: full_t <= pwdata[`CCS_TIME];
          // a zero discharge setting is stored as the shortest legal one
          `CCS_A_DIS: dis_t <= (pwdata[`CCS_TIME] == 10'h000) ? `CCS_DIS_RST :
                               pwdata[`CCS_TIME];
          `CCS_A_BANK0: bank0 <= pwdata[17:0];
          `CCS_A_BANK1: bank1 <= pwdata[17:0];
          `CCS_A_IVL: ivl <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // trigger sources; a new event wins over the clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pend <= 1'b0;
      pin_pend <= 1'b0;
      thit <= 1'b0;
      tcnt <= 17'h00000;
      div4 <= 2'h0;
    end else if (ce) begin
      cmd_pend <= cmd_evt | (cmd_pend & ~go);
      pin_pend <= pin_rise | (pin_pend & ~go);
      thit <= treach | (thit & ~go);
      if (go & m_stretch)
        tcnt <= 17'h00000;
      else if (treach)
        tcnt <= 17'h00000;
      else if (olf_rise)
        tcnt <= tcnt_inc;
      if (ohf_rise)
        div4 <= div4 + 2'h1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      s_topo <= `CCS_TOPO_RST;
      s_pre <= 10'h000;
      s_full <= 10'h000;
      s_dis <= `CCS_DIS_RST;
      slot <= `CCS_SLOT_REF;
      kind <= `CCS_K_LO;
      fake_left <= 4'h0;
      seq_left <= 13'h0000;
      pcnt <= 11'h000;
      mcnt <= {MEAS_W{1'b0}};
      tripped <= 1'b0;
      armed <= 1'b0;
      conv_cnt <= 16'h0000;
      res_port <= 4'h0;
      lower_port_switch <= 1'b0;
      upper_port_switch <= 1'b0;
      lower_port_index <= 4'h0;
      upper_port_index <= 4'h0;
      dummy_charge_enable <= 1'b0;
      dc_dummy_active <= 1'b0;
      result_strobe <= 1'b0;
      result_time <= {MEAS_W{1'b0}};
      result_fake <= 1'b0;
      end_of_conversion <= 1'b0;
      conversion_busy <= 1'b0;
    end else if (ce) begin
      result_strobe <= 1'b0;
      end_of_conversion <= 1'b0;
      if (tick)
        pcnt <= pcnt_inc;
      case (st)
        S_IDLE: begin
          if (go) begin
            s_topo <= topo;
            s_pre <= pre_t;
            s_full <= full_t;
            s_dis <= dis_t;
            fake_left <= topo[`CCS_T_FAKE];
            seq_left <= (avg <= 13'h0001) ? 13'h0001 : avg;
            slot <= `CCS_SLOT_REF;
            kind <= `CCS_K_LO;
            conversion_busy <= 1'b1;
            st <= S_SEEK;
          end
        end
        S_SEEK: begin
          pcnt <= 11'h000;
          mcnt <= {MEAS_W{1'b0}};
          tripped <= 1'b0;
          armed <= 1'b0;
          if (slot >= `CCS_SLOT_END) begin
            slot <= `CCS_SLOT_REF;
            kind <= `CCS_K_LO;
            if (fake_left != 4'h0)
              fake_left <= fake_left - 4'h1;
            else if (seq_left > 13'h0001)
              seq_left <= seq_left - 13'h0001;
            else
              st <= S_DONE;
          end else if (slot_ok & kind_ok) begin
            lower_port_switch <= sw_lo;
            upper_port_switch <= sw_up & floating;
            lower_port_index <= lo_idx;
            upper_port_index <= lo_idx | 4'h1;
            // the idle electrode of a differential pair follows the dummy charge
            dummy_charge_enable <= s_topo[`CCS_T_FORCE] & s_topo[`CCS_T_DIFF]
                                   & (sw_lo ^ sw_up);
            dc_dummy_active <= (kind == `CCS_K_DC);
            if (s_pre != 10'h000)
              st <= S_PRE;
            else if (s_full != 10'h000)
              st <= S_FULL;
            else
              st <= S_DIS;
          end else begin
            slot <= last_kind ? (slot + 4'h1) : slot;
            kind <= last_kind ? `CCS_K_LO : (kind + 3'h1);
          end
        end
        S_PRE: begin
          if (phase_end) begin
            pcnt <= 11'h000;
            st <= (s_full != 10'h000) ? S_FULL : S_DIS;
          end
        end
        S_FULL: begin
          if (phase_end) begin
            pcnt <= 11'h000;
            st <= S_DIS;
          end
        end
        S_DIS: begin
          // the time stops at the first sampled trip; it saturates if none comes
          // a trip still high from the previous discharge must drop once before it counts
          if (comp_trip & armed)
            tripped <= 1'b1;
          else if (~tripped & (mcnt_inc != {MEAS_W{1'b0}}))
            mcnt <= mcnt_inc;
          if (~comp_trip)
            armed <= 1'b1;
          if (phase_end) begin
            result_time <= mcnt;
            result_fake <= (fake_left != 4'h0);
            result_strobe <= 1'b1;
            res_port <= lower_port_index;
            lower_port_switch <= 1'b0;
            upper_port_switch <= 1'b0;
            dummy_charge_enable <= 1'b0;
            dc_dummy_active <= 1'b0;
            slot <= last_kind ? (slot + 4'h1) : slot;
            kind <= last_kind ? `CCS_K_LO : (kind + 3'h1);
            st <= S_SEEK;
          end
        end
        S_DONE: begin
          end_of_conversion <= 1'b1;
          conversion_busy <= 1'b0;
          conv_cnt <= conv_cnt + 16'h0001;
          st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule // ccs_sequencer

// ===== verif/ccs_sensor_model.sv
`timescale 1ns/1ps
module ccs_sensor_model (
  input wire pclk,
  input wire discharge_active,
  input wire slow,
  output logic low_freq_oscillator,
  output logic high_freq_oscillator,
  output logic discharge_comparator
);
  int cnt = 0;
  initial low_freq_oscillator = 1'b0;
  initial high_freq_oscillator = 1'b0;
  initial discharge_comparator = 1'b0;
  // edges land on falling pclk edges, half a period from the rising edges the synchronisers sample
  always #200 low_freq_oscillator = ~low_freq_oscillator;
  always #40 high_freq_oscillator = ~high_freq_oscillator;
  // trips early or late within a discharge; stays high one cycle after the discharge ends
  always @(posedge pclk) begin
    cnt <= discharge_active ? cnt + 1 : 0;
    discharge_comparator <= discharge_active && cnt >= (slow ? 20 : 3);
  end
endmodule // ccs_sensor_model

// ===== verif/ccs_sequencer_properties.sv
`timescale 1ns/1ps
module ccs_sequencer_properties (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire lower_port_switch,
  input wire upper_port_switch,
  input wire [3:0] lower_port_index,
  input wire [3:0] upper_port_index,
  input wire dummy_charge_enable,
  input wire precharge_active,
  input wire fullcharge_active,
  input wire discharge_active,
  input wire result_strobe,
  input wire result_fake,
  input wire end_of_conversion,
  input wire conversion_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg real_seen;
  wire ph = precharge_active | fullcharge_active | discharge_active;
  // cleared at each end so the next conversion may open with fakes again
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      real_seen <= 1'b0;
    else if (end_of_conversion)
      real_seen <= 1'b0;
    else if (result_strobe && !result_fake)
      real_seen <= 1'b1;
  end
  property p_apb_ans;
    psel && !penable && ce |=> pready;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("no ready after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_eoc_pulse;
    end_of_conversion |=> !end_of_conversion;
  endproperty
  a_eoc_pulse: assert property (p_eoc_pulse) else $error("eoc too long");
  property p_eoc_busy;
    end_of_conversion |-> $past(conversion_busy);
  endproperty
  a_eoc_busy: assert property (p_eoc_busy) else $error("eoc while idle");
  property p_phase_busy;
    ph |-> conversion_busy;
  endproperty
  a_phase_busy: assert property (p_phase_busy) else $error("phase while idle");
  property p_phase_one;
    $onehot0({precharge_active, fullcharge_active, discharge_active});
  endproperty
  a_phase_one: assert property (p_phase_one) else $error("phases overlap");
  property p_dis_strobe;
    $fell(discharge_active) |-> ##[0:1] result_strobe;
  endproperty
  a_dis_strobe: assert property (p_dis_strobe) else $error("no result");
  property p_force;
    ph && dummy_charge_enable |-> lower_port_switch ^ upper_port_switch;
  endproperty
  a_force: assert property (p_force) else $error("dummy charge misplaced");
  property p_pair;
    ph |-> upper_port_index == (lower_port_index | 4'h1) && lower_port_index <= 4'h9;
  endproperty
  a_pair: assert property (p_pair) else $error("bad port index");
  property p_fake_first;
    result_strobe && result_fake |-> !real_seen;
  endproperty
  a_fake_first: assert property (p_fake_first) else $error("fake after real");
  c_force: cover property (ph && dummy_charge_enable);
  c_fake: cover property (result_strobe && result_fake);
  c_eoc: cover property (end_of_conversion);
endmodule // ccs_sequencer_properties
bind ccs_sequencer ccs_sequencer_properties ccs_sequencer_properties_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .lower_port_switch(lower_port_switch),
  .upper_port_switch(upper_port_switch), .lower_port_index(lower_port_index),
  .upper_port_index(upper_port_index), .dummy_charge_enable(dummy_charge_enable),
  .precharge_active(precharge_active), .fullcharge_active(fullcharge_active),
  .discharge_active(discharge_active), .result_strobe(result_strobe),
  .result_fake(result_fake), .end_of_conversion(end_of_conversion),
  .conversion_busy(conversion_busy)
);

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "ccs_defines.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic trigger_pin = 1'b0;
  logic start_request = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire [15:0] result_time;
  wire [3:0] lower_port_index;
  wire [3:0] upper_port_index;
  wire pready, pslverr, low_freq_oscillator, high_freq_oscillator, discharge_comparator;
  wire lower_port_switch, upper_port_switch, dummy_charge_enable, dc_dummy_active;
  wire precharge_active, fullcharge_active, discharge_active, result_strobe;
  wire result_fake, end_of_conversion, conversion_busy;
  int err_count = 0;
  int tests_run = 0;
  int pt, ft, dt, tk, pc, fc, dc, opn, tot, fk, ic, tt;
  logic [32:0] exp_r;
  logic [47:0] exp_c;
  logic [32:0] rq[$];
  logic [47:0] cq[$];
  logic [47:0] last;
  logic [21:0] cfg[5] = '{22'h000558, 22'h028320, 22'h0303C9, 22'h0305F3, 22'h03010A};
  always #5 pclk = ~pclk;
  ccs_sequencer ccs_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_freq_oscillator(low_freq_oscillator),
    .high_freq_oscillator(high_freq_oscillator), .discharge_comparator(discharge_comparator),
    .trigger_pin(trigger_pin), .start_request(start_request),
    .lower_port_switch(lower_port_switch), .upper_port_switch(upper_port_switch),
    .lower_port_index(lower_port_index), .upper_port_index(upper_port_index),
    .dummy_charge_enable(dummy_charge_enable), .dc_dummy_active(dc_dummy_active),
    .precharge_active(precharge_active), .fullcharge_active(fullcharge_active),
    .discharge_active(discharge_active), .result_strobe(result_strobe),
    .result_time(result_time), .result_fake(result_fake),
    .end_of_conversion(end_of_conversion), .conversion_busy(conversion_busy)
  );
  ccs_sensor_model ccs_sensor_model_inst (
    .pclk(pclk), .discharge_active(discharge_active), .slow(slow),
    .low_freq_oscillator(low_freq_oscillator), .high_freq_oscillator(high_freq_oscillator),
    .discharge_comparator(discharge_comparator)
  );
  // measurements expected in one sequence of the given topology word
  function automatic int nseq(input logic [21:0] t);
    int n = 0;
    if (t[1])
      for (int k = 0; k < 4; k++) n += t[8 + 2 * k] ? 2 + t[4] + 2 * t[5] + t[6] : 0;
    else
      for (int k = 0; k < 8; k++) n += t[8 + k] ? 1 + t[5] + (t[6] & t[0]) : 0;
    return n + t[3];
  endfunction
  // a first tick may come at once after entry, so one period of slack below
  function automatic logic rng(input int c, input int t);
    return t == 0 ? c == 0 : (c >= (t - 1) * tk - 1 && c <= t * tk + 3);
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_r = rq.pop_front();
      `CHK({pslverr, prdata}, exp_r)
    end
    pc += precharge_active;
    fc += fullcharge_active;
    dc += discharge_active;
    if (discharge_active && !lower_port_switch && !upper_port_switch && !dc_dummy_active)
      opn = 1;
    if (result_strobe === 1'b1) begin
      `CHK({rng(pc, pt), rng(fc, ft), rng(dc, dt)}, 3'b111)
      // model trip threshold plus model flop and two synchroniser stages
      tt = slow ? 23 : 6;
      `CHK(result_time, 16'(dc - 1 < tt ? dc - 1 : tt))
      tot++;
      fk += result_fake;
      ic += opn;
      pc = 0;
      fc = 0;
      dc = 0;
      opn = 0;
    end
    if (end_of_conversion === 1'b1) begin
      exp_c = cq.pop_front();
      `CHK({ic[15:0], fk[15:0], tot[15:0]}, exp_c)
      tot = 0;
      fk = 0;
      ic = 0;
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    end_sim();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      tmo();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_done();
    int n = 0;
    while (cq.size() > 0 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40000)
      tmo();
  endtask
  task automatic wait_busy(input logic v, inout int n, input int lim);
    while (conversion_busy !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (conversion_busy !== v)
      tmo();
  endtask
  task automatic conv(input logic [21:0] t, input int i);
    int f, a, p, q, d, s;
    logic [21:0] tw;
    f = $urandom_range(1, i % 2);
    p = $urandom_range(2, 0);
    q = $urandom_range(1, 0);
    d = $urandom_range(2, 1);
    tw = t | (22'(f) << 18);
    s = nseq(tw);
    a = i[0] ? 2 : 1;
    tk = t[17:16] == 2'h0 ? 40 : (t[17:16] == 2'h2 ? 32 : 8);
    pt = p;
    ft = q ? q + 2 : 0;
    dt = d + 1;
    slow <= i[1];
    apb(1'b1, `CCS_A_TOPO, {10'h000, tw});
    apb(1'b1, `CCS_A_PRE, 32'(p));
    apb(1'b1, `CCS_A_FULL, 32'(q));
    apb(1'b1, `CCS_A_DIS, 32'(d));
    last = {16'(t[3] * (f + a)), 16'(f * s), 16'(s * (f + a))};
    cq.push_back(last);
    apb(1'b1, `CCS_A_CTRL, {29'h0, i[0], ~i[0], 1'b1});
    if (i[0]) begin
      start_request <= 1'b1;
      @(posedge pclk);
      start_request <= 1'b0;
    end
    wait_done();
  endtask
  initial begin
    int n;
    void'($urandom(96626));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CCS_A_TOPO, {1'b0, 32'h0000_0108});
    rd(`CCS_A_PRE, 33'h0);
    rd(8'h28, {1'b1, 32'h0});
    apb(1'b1, `CCS_A_DIS, 32'h0);
    rd(`CCS_A_DIS, {1'b0, 32'h1});
    apb(1'b1, `CCS_A_BANK0, 32'h0001_0000);
    apb(1'b1, `CCS_A_BANK1, 32'h0001_0002);
    for (int i = 0; i < 5; i++)
      conv(cfg[i], i);
    apb(1'b1, `CCS_A_BANK0, 32'h0);
    apb(1'b1, `CCS_A_CTRL, 32'h3);
    repeat (200) @(posedge pclk);
    `CHK(conversion_busy, 1'b0)
    cq.push_back(last);
    apb(1'b1, `CCS_A_BANK0, 32'h0003_0000);
    trigger_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    trigger_pin <= 1'b0;
    wait_done();
    cq.push_back(last);
    cq.push_back(last);
    apb(1'b1, `CCS_A_IVL, 32'h1);
    apb(1'b1, `CCS_A_BANK0, 32'h0001_0000);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (end_of_conversion !== 1'b1 && n < 40000);
    if (end_of_conversion !== 1'b1)
      tmo();
    n = 0;
    while (conversion_busy !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n <= 3, 1'b1)
    apb(1'b1, `CCS_A_CTRL, 32'h0);
    wait_done();
    // stretched: starts 32 olf periods apart, the conversion itself is much shorter
    cq.push_back(last);
    cq.push_back(last);
    apb(1'b1, `CCS_A_IVL, 32'h10);
    apb(1'b1, `CCS_A_BANK0, 32'h0);
    apb(1'b1, `CCS_A_CTRL, 32'h1);
    n = 0;
    wait_busy(1'b1, n, 400);
    n = 0;
    wait_busy(1'b0, n, 1400);
    wait_busy(1'b1, n, 1400);
    `CHK(n >= 1230 && n <= 1300, 1'b1)
    apb(1'b1, `CCS_A_CTRL, 32'h0);
    wait_done();
    repeat (300) @(posedge pclk);
    end_sim();
  end
endmodule // tb
